// ==== hdl/std_timer_regs.vh ====
// Notes on behaviour
// - Run-enable rising edge returns the output to its initial level (compare, PWM, pulse).
// - Mode field bits 7:6: 00 compare, 01 capture, 10 PWM/pulse, 11 timer.
// - Timer/counter mode leaves the output pin undriven.
// - Compare mode on A match: 00 hold, 01 low, 10 high, 11 toggle.
// - PWM mode function: 00 inactive, 01 active, 10 PWM, 11 single pulse.
// - Capture mode edge: 00 rise, 01 fall, 10 both, 11 none.
// - Requested level equal to initial level gives no visible change on match.
// - Bit 3 sets initial level, PWM active level, pulse start level.
// - Bit 2 inverts the output pin; no effect in timer/counter mode.
// - Bit 1 swaps PWM period and duty roles of the two compare values.
// - Bit 0 set clears on A match; clear on P match or overflow.
// - Clear select ignored in PWM, single pulse and capture modes.
// - Compare mode, clear select low: both A and P flags raised.
// - Compare mode, clear select high: only A flag, never P flag.
// - Zero full compare value: overflow at ffff with no A flag.
// - In compare mode only A match changes the output; P never.
// - Timer/counter mode counts and flags exactly like compare mode, no pin.
// - Three low bits of the run/clock control register read zero.
// - Run-enable rise clears the counter; fall freezes it.
// - Upper compare value matches counter bits 15:8 while bits 7:0 are zero.
// - Sixteen-bit up-counter; comparator A compares all sixteen bits.
`ifndef STD_TIMER_REGS_VH
`define STD_TIMER_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_RUN_CTRL    3'h0
`define ADDR_MODE_CTRL   3'h1
`define ADDR_CNT_LO      3'h2
`define ADDR_CNT_HI      3'h3
`define ADDR_CMPA_LO     3'h4
`define ADDR_CMPA_HI     3'h5
`define ADDR_CMPP        3'h6
`define ADDR_FLAGS       3'h7

// ----------------------------------------------------------------
// Fields and codes
// ----------------------------------------------------------------
`define RUN_ENABLE_BIT   3
`define FLAG_A_BIT       0
`define FLAG_P_BIT       1
`define MODE_COMPARE     2'h0
`define MODE_CAPTURE     2'h1
`define MODE_PWM         2'h2
`define MODE_TIMER       2'h3
`define FN_PWM_INACTIVE  2'h0
`define FN_PWM_ACTIVE    2'h1
`define FN_PWM_WAVE      2'h2
`define FN_PULSE         2'h3
`define RESET_BYTE       8'h00

`endif

// ==== hdl/std_timer.v ====
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "std_timer_regs.vh"

module std_timer
  #(
    parameter CNT_W = 16
  )
  (
    // Clock and reset
    input  wire       i_clk_sys,
    input  wire       i_arst_n,
    // Register port
    input  wire [2:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    // Timer clock tick and pins
    input  wire       i_tick,
    input  wire       i_capture_input_pin,
    output reg        o_timer_output_pin,
    output reg        o_timer_output_pin_oe,
    output reg        o_match_a_flag,
    output reg        o_match_p_flag
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]       timer_run_clock_control_reg;
  reg  [7:0]       timer_mode_output_control_reg;
  reg  [CNT_W-1:0] count_reg;
  reg  [15:0]      compare_value_full_reg;
  reg  [7:0]       compare_value_upper_reg;
  reg  [7:0]       cmpa_lo_buf_reg;
  reg              run_d_reg;
  reg              out_level_reg;
  reg              cap_d_reg;
  reg              pwm_wave;

  wire [1:0] mode     = timer_mode_output_control_reg[7:6];
  wire [1:0] pin_fn   = timer_mode_output_control_reg[5:4];
  wire       init_lvl = timer_mode_output_control_reg[3];
  wire       invert   = timer_mode_output_control_reg[2];
  wire       dp_swap  = timer_mode_output_control_reg[1];
  wire       clr_sel  = timer_mode_output_control_reg[0];
  wire       run      = timer_run_clock_control_reg[`RUN_ENABLE_BIT];
  wire       paused   = timer_run_clock_control_reg[7];
  wire       run_rise = run & ~run_d_reg;
  wire       cmp_like = (mode == `MODE_COMPARE) || (mode == `MODE_TIMER);
  wire       step     = run & ~paused & i_tick;
  wire       pulse_md = (mode == `MODE_PWM) && (pin_fn == `FN_PULSE);

  // Comparators; zero full value never matches so overflow passes silently
  wire match_a = step && (count_reg == compare_value_full_reg)
                 && (compare_value_full_reg != 16'h0000);
  wire match_p = step && (count_reg[15:8] == compare_value_upper_reg)
                 && (count_reg[7:0] == 8'h00)
                 && (compare_value_upper_reg != 8'h00);

  // Capture edge select
  reg cap_evt;
  always @*
  begin
    case (pin_fn)
      2'h0:    cap_evt = i_capture_input_pin & ~cap_d_reg;
      2'h1:    cap_evt = ~i_capture_input_pin & cap_d_reg;
      2'h2:    cap_evt = i_capture_input_pin ^ cap_d_reg;
      default: cap_evt = 1'b0;
    endcase
  end

  // Period/duty roles
  reg [15:0] period_end;
  reg [15:0] duty_val;
  always @*
  begin
    if (!dp_swap)
    begin
      period_end = {compare_value_upper_reg, 8'h00};
      duty_val   = compare_value_full_reg;
    end
    else
    begin
      period_end = compare_value_full_reg;
      duty_val   = {compare_value_upper_reg, 8'h00};
    end
    // Zero upper value means full 65536 period/duty
    pwm_wave = ((period_end == 16'h0000) && !dp_swap) ? (count_reg < duty_val)
             : (count_reg < duty_val) || (duty_val == 16'h0000 && dp_swap);
  end

  // Period reached in PWM mode
  wire pwm_wrap = step && (period_end != 16'h0000) && (count_reg == period_end - 16'h0001);

  // ----------------------------------------------------------------
  // Counter, flags and output level
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count_reg       <= 16'h0000;
      run_d_reg       <= 1'b0;
      cap_d_reg       <= 1'b0;
      out_level_reg   <= 1'b0;
      o_match_a_flag  <= 1'b0;
      o_match_p_flag  <= 1'b0;
    end
    else
    begin
      run_d_reg <= run;
      cap_d_reg <= i_capture_input_pin;
      if (run_rise)
        count_reg <= 16'h0000;
      else if (step)
      begin
        if (cmp_like && clr_sel && match_a)
          count_reg <= 16'h0000;
        else if (!cmp_like && mode == `MODE_PWM && !pulse_md && pwm_wrap)
          count_reg <= 16'h0000;
        else if ((cmp_like && !clr_sel || mode == `MODE_CAPTURE) && match_p)
          count_reg <= 16'h0000;
        else
          count_reg <= count_reg + 16'h0001;
      end
      // Output level: reload on run rise, else compare action
      if (run_rise)
        out_level_reg <= init_lvl;
      else if (mode == `MODE_COMPARE && match_a)
      begin
        case (pin_fn)
          2'h1:    out_level_reg <= 1'b0;
          2'h2:    out_level_reg <= 1'b1;
          2'h3:    out_level_reg <= ~out_level_reg;
          default: out_level_reg <= out_level_reg;
        endcase
      end
      else if (pulse_md && match_a)
        out_level_reg <= ~init_lvl;
      // Sticky flags; set wins over software clear
      if ((cmp_like || mode == `MODE_PWM) && match_a)
        o_match_a_flag <= 1'b1;
      else if (mode == `MODE_CAPTURE && run && cap_evt)
        o_match_a_flag <= 1'b1;
      else if (i_wr && i_addr == `ADDR_FLAGS && i_wdata[`FLAG_A_BIT])
        o_match_a_flag <= 1'b0;
      if (match_p && !(cmp_like && clr_sel) && !pulse_md)
        o_match_p_flag <= 1'b1;
      else if (i_wr && i_addr == `ADDR_FLAGS && i_wdata[`FLAG_P_BIT])
        o_match_p_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes, capture and pulse auto-stop
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      timer_run_clock_control_reg   <= `RESET_BYTE;
      timer_mode_output_control_reg <= `RESET_BYTE;
      compare_value_full_reg        <= 16'h0000;
      compare_value_upper_reg       <= `RESET_BYTE;
      cmpa_lo_buf_reg               <= `RESET_BYTE;
    end
    else
    begin
      if (i_wr)
      begin
        case (i_addr)
          `ADDR_RUN_CTRL:  timer_run_clock_control_reg <= {i_wdata[7:3], 3'h0};
          `ADDR_MODE_CTRL: timer_mode_output_control_reg <= i_wdata;
          // Low byte is held until the high byte lands, so both change together
          `ADDR_CMPA_LO:   cmpa_lo_buf_reg <= i_wdata;
          `ADDR_CMPA_HI:   compare_value_full_reg <= {i_wdata, cmpa_lo_buf_reg};
          `ADDR_CMPP:      compare_value_upper_reg <= i_wdata;
          default:         cmpa_lo_buf_reg <= cmpa_lo_buf_reg;
        endcase
      end
      else if (pulse_md && match_a)
        timer_run_clock_control_reg[`RUN_ENABLE_BIT] <= 1'b0;
      if (mode == `MODE_CAPTURE && run && cap_evt)
        compare_value_full_reg <= count_reg;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and read port
  // ----------------------------------------------------------------
  reg pin_level;
  always @*
  begin
    case (mode)
      `MODE_PWM:
        case (pin_fn)
          `FN_PWM_INACTIVE: pin_level = ~init_lvl;
          `FN_PWM_ACTIVE:   pin_level = init_lvl;
          `FN_PWM_WAVE:     pin_level = pwm_wave ? init_lvl : ~init_lvl;
          default:          pin_level = run ? out_level_reg : ~init_lvl;
        endcase
      default: pin_level = out_level_reg;
    endcase
  end

  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_timer_output_pin    <= 1'b0;
      o_timer_output_pin_oe <= 1'b0;
      o_rdata               <= 8'h00;
    end
    else
    begin
      o_timer_output_pin    <= pin_level ^ invert;
      o_timer_output_pin_oe <= (mode == `MODE_COMPARE) || (mode == `MODE_PWM);
      if (i_rd)
      begin
        case (i_addr)
          `ADDR_RUN_CTRL:  o_rdata <= timer_run_clock_control_reg;
          `ADDR_MODE_CTRL: o_rdata <= timer_mode_output_control_reg;
          `ADDR_CNT_LO:    o_rdata <= count_reg[7:0];
          `ADDR_CNT_HI:    o_rdata <= count_reg[15:8];
          `ADDR_CMPA_LO:   o_rdata <= compare_value_full_reg[7:0];
          `ADDR_CMPA_HI:   o_rdata <= compare_value_full_reg[15:8];
          `ADDR_CMPP:      o_rdata <= compare_value_upper_reg;
          default:         o_rdata <= {6'h00, o_match_p_flag, o_match_a_flag};
        endcase
      end
      else
        o_rdata <= 8'h00;
    end
  end

endmodule // std_timer

`default_nettype wire

// ==== tb/capture_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------
// Far-side pins
// ----------
module capture_source_model (
  input  wire logic i_clk_sys,
  input  wire logic i_level,
  input  wire logic i_timer_output_pin,
  input  wire logic i_timer_output_pin_oe,
  output var  logic o_capture_input_pin,
  output wire logic o_pin_wire
);
  logic last_reg = 1'b0;
  // Capture source changes only just after an edge, as a synchronised input
  always @(posedge i_clk_sys)
  begin
    o_capture_input_pin <= i_level;
    if (i_timer_output_pin_oe)
      last_reg <= i_timer_output_pin;
  end
  // No pull on the pin: a released pin shows the inverse of its last level
  assign o_pin_wire = i_timer_output_pin_oe ? i_timer_output_pin : !last_reg;
endmodule // capture_source_model
`default_nettype wire

// ==== tb/std_timer_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------
// Port checks
// ----------
module std_timer_assertions #(parameter CNT_W = 16) (
  input wire logic       i_clk_sys,
  input wire logic       i_arst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_tick,
  input wire logic       i_capture_input_pin,
  input wire logic       o_timer_output_pin,
  input wire logic       o_timer_output_pin_oe,
  input wire logic       o_match_a_flag,
  input wire logic       o_match_p_flag
);
  logic [7:0] mode_reg;
  logic [1:0] settle_reg;
  // Mode shadow; checks wait three cycles for the write to land inside
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mode_reg   <= 8'h00;
      settle_reg <= 2'h0;
    end
    else if (i_wr && i_addr == 3'h1)
    begin
      mode_reg   <= i_wdata;
      settle_reg <= 2'h0;
    end
    else if (settle_reg != 2'h3)
      settle_reg <= settle_reg + 2'h1;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  mode_oe_a: assert property (settle_reg == 2'h3 |-> o_timer_output_pin_oe == !mode_reg[6])
    else $error("oe vs mode");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("rdata not idle");
  run_low_a: assert property ($past(i_rd) && $past(i_addr) == 3'h0 |-> o_rdata[2:0] == 3'h0)
    else $error("run low bits");
  flag_read_a: assert property ($past(i_rd) && $past(i_addr) == 3'h7 |->
    o_rdata == {6'h00, $past(o_match_p_flag), $past(o_match_a_flag)})
    else $error("flag read");
  a_hold_a: assert property ($past(o_match_a_flag)
    && !$past(i_wr && i_addr == 3'h7 && i_wdata[0]) |-> o_match_a_flag)
    else $error("a flag lost");
  p_hold_a: assert property ($past(o_match_p_flag)
    && !$past(i_wr && i_addr == 3'h7 && i_wdata[1]) |-> o_match_p_flag)
    else $error("p flag lost");
  p_quiet_a: assert property (settle_reg == 2'h3 && mode_reg[7] == mode_reg[6] && mode_reg[0]
    |-> !$rose(o_match_p_flag))
    else $error("p flag raised");
  a_tick_a: assert property ($rose(o_match_a_flag) && mode_reg[7:6] != 2'h1
    |-> $past(i_tick) || $past(i_tick, 2))
    else $error("a flag without tick");
  cover property ($rose(o_match_a_flag));
  cover property ($rose(o_match_p_flag));
  cover property (o_timer_output_pin_oe && $changed(o_timer_output_pin));
endmodule // std_timer_assertions
bind std_timer std_timer_assertions #(.CNT_W(CNT_W)) i_chk (.i_clk_sys(i_clk_sys),
  .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_tick(i_tick), .i_capture_input_pin(i_capture_input_pin),
  .o_timer_output_pin(o_timer_output_pin), .o_timer_output_pin_oe(o_timer_output_pin_oe),
  .o_match_a_flag(o_match_a_flag), .o_match_p_flag(o_match_p_flag));
`default_nettype wire

// ==== tb/std_timer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "std_timer_regs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module std_timer_test;
  logic       i_clk_sys = 1'b0;
  logic       i_arst_n = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       i_tick = 1'b0;
  logic       cap_level = 1'b0;
  logic [7:0] rd_val;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         cycles = 0;
  wire  [7:0] o_rdata;
  wire        cap_pin, o_pin, o_oe, flag_a, flag_p, pin_wire;
  // Mode byte, pin at run start, pin after match A, output enable
  // The PWM wave row runs past a duty of three; single pulse ends at match A
  logic [10:0] rows [0:10] = '{{8'h00, 3'b001}, {8'h18, 3'b101}, {8'h20, 3'b011},
    {8'h28, 3'b111}, {8'h30, 3'b011}, {8'h3c, 3'b011}, {8'hc0, 3'b000},
    {8'h98, 3'b111}, {8'h88, 3'b001}, {8'ha8, 3'b101}, {8'hb8, 3'b101}};
  std_timer i_dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tick(i_tick),
    .i_capture_input_pin(cap_pin), .o_timer_output_pin(o_pin),
    .o_timer_output_pin_oe(o_oe), .o_match_a_flag(flag_a), .o_match_p_flag(flag_p));
  capture_source_model i_far (.i_clk_sys(i_clk_sys), .i_level(cap_level),
    .i_timer_output_pin(o_pin), .i_timer_output_pin_oe(o_oe),
    .o_capture_input_pin(cap_pin), .o_pin_wire(pin_wire));
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge i_clk_sys) i_tick <= 1'b1;
    @(posedge i_clk_sys);
    i_tick <= 1'b0;
    #1;
  endtask
  // Timer is stopped before any mode change, then restarted
  task automatic start(input logic [7:0] m, lo, hi, up);
    wr(`ADDR_RUN_CTRL, 8'h00);
    wr(`ADDR_MODE_CTRL, m);
    wr(`ADDR_CMPA_LO, lo);
    wr(`ADDR_CMPA_HI, hi);
    wr(`ADDR_CMPP, up);
    wr(`ADDR_FLAGS, 8'h03);
    wr(`ADDR_RUN_CTRL, 8'h08);
    settle(3);
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    rd(`ADDR_MODE_CTRL, rd_val);
    `CHK(rd_val, `RESET_BYTE)
    foreach (rows[k])
    begin
      start(rows[k][10:3], 8'h03, 8'h00, 8'h00);
      if (rows[k][0]) `CHK(pin_wire, rows[k][2])
      `CHK(o_oe, rows[k][0])
      ticks(6);
      settle(2);
      if (rows[k][0]) `CHK(pin_wire, rows[k][1])
      `CHK(flag_a, 1'b1)
    end
    start(8'hc0, 8'h80, 8'h00, 8'h00);
    ticks(5);
    wr(`ADDR_RUN_CTRL, 8'h07);
    ticks(3);
    rd(`ADDR_CNT_LO, rd_val);
    `CHK(rd_val, 8'h05)
    rd(`ADDR_RUN_CTRL, rd_val);
    `CHK(rd_val, 8'h00)
    wr(`ADDR_RUN_CTRL, 8'h08);
    settle(3);
    rd(`ADDR_CNT_LO, rd_val);
    `CHK(rd_val, 8'h00)
    for (int c = 0; c < 2; c++)
    begin
      start(c[7:0], 8'h80, c[7:0], 8'h01);
      ticks(400);
      `CHK(flag_a, 1'b1)
      `CHK(flag_p, !c[0])
      rd(`ADDR_CNT_HI, rd_val);
      `CHK(rd_val, 8'h00)
      wr(`ADDR_FLAGS, 8'h03);
      settle(2);
      `CHK(flag_a, 1'b0)
    end
    for (int f = 0; f < 4; f++)
    begin
      start({2'b01, f[1:0], 4'h0}, 8'h00, 8'h00, 8'h00);
      cap_level <= 1'b1;
      settle(4);
      `CHK(flag_a, f[0] == 1'b0 && f != 3)
      wr(`ADDR_FLAGS, 8'h03);
      cap_level <= 1'b0;
      settle(4);
      `CHK(flag_a, f == 1 || f == 2)
    end
    start(8'h00, 8'h00, 8'h00, 8'h00);
    ticks(6);
    `CHK(flag_a, 1'b0)
    start(8'h00, 8'h03, 8'h00, 8'h00);
    ticks(6);
    i_arst_n <= 1'b0;
    settle(2);
    `CHK({o_pin, o_oe, flag_a, flag_p}, 4'h0)
    i_arst_n <= 1'b1;
    rd(`ADDR_MODE_CTRL, rd_val);
    `CHK(rd_val, `RESET_BYTE)
    close_out();
  end
endmodule // std_timer_test
`default_nettype wire
